/* File: blcr_pkg.sv */
// package for the buck load-current readout block
package blcr_pkg;
   // register byte addresses on the internal register port
   localparam logic [7:0] BLCR_ADDR_SELECT = 8'h24;
   localparam logic [7:0] BLCR_ADDR_HIGH = 8'h25;
   localparam logic [7:0] BLCR_ADDR_LOW = 8'h26;
   // values after reset
   localparam logic [7:0] BLCR_SELECT_RST = 8'h00;
   localparam logic [8:0] BLCR_RESULT_RST = 9'h001;
   localparam int BLCR_RESULT_W = 9;
   // register access from the serial control interface
   typedef struct packed
   {
      logic wr_en;
      logic [7:0] addr;
      logic [7:0] wdata;
   } blcr_reg_req_s;
   typedef enum logic [2:0]
   {
      BLCR_IDLE = 3'b001,
      BLCR_WAIT = 3'b010,
      BLCR_LOAD = 3'b100
   } blcr_state_e;
endpackage

/* File: blcr_readout.sv */
// buck load-current readout register front end
`timescale 1ns/1ps
// Operation
// - any write to the select register while clk_en is high starts a new measurement
// - select bit 0 picks converter zero (0) or converter one (1)
// - with dual_phase set, selected master reports summed master plus slave current
// - selected slave reports only its own current
// - result bit 8 sits in bit 0 of high register, 20 mA per count
// - result bits 7:0 sit in the low register
// - reserved bits of select and high registers read zero
// - select register lives at address 0x24
module blcr_readout
(
   input wire logic core_clk,
   input wire logic rst_b,
   input wire logic clk_en,
   input wire blcr_pkg::blcr_reg_req_s reg_req,
   input wire logic [7:0] reg_raddr,
   output logic [7:0] reg_rdata,
   output logic meas_start,
   output logic meas_sel,
   input wire logic meas_done,
   input wire logic [blcr_pkg::BLCR_RESULT_W-1:0] meas_zero_cur,
   input wire logic [blcr_pkg::BLCR_RESULT_W-1:0] meas_one_cur,
   input wire logic dual_phase,
   input wire logic master_is_one,
   output logic meas_busy
);
   import blcr_pkg::*;

   // ----------------------------------------
   // select register and start
   // ----------------------------------------
   logic sel_r;
   logic start_r;
   logic wr_sel;
   assign wr_sel = reg_req.wr_en && (reg_req.addr == BLCR_ADDR_SELECT);

   always_ff @(posedge core_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         sel_r <= BLCR_SELECT_RST[0];
         start_r <= 1'b0;
      end
      else if (clk_en)
      begin
         start_r <= wr_sel;
         if (wr_sel)
         begin
            // reserved bits are not stored, so they always read zero
            sel_r <= reg_req.wdata[0];
         end
      end
   end

   // ----------------------------------------
   // measurement sequencer
   // ----------------------------------------
   blcr_state_e state_r;
   logic [BLCR_RESULT_W-1:0] result_r;
   logic [BLCR_RESULT_W-1:0] pick;
   logic [BLCR_RESULT_W:0] sum;
   logic sel_is_master;

   assign sel_is_master = dual_phase && (sel_r == master_is_one);
   assign sum = {1'b0, meas_zero_cur} + {1'b0, meas_one_cur};

   always_comb
   begin
      if (sel_is_master)
      begin
         // saturate at full scale rather than wrap
         pick = sum[BLCR_RESULT_W] ? '1 : sum[BLCR_RESULT_W-1:0];
      end
      else
      begin
         pick = sel_r ? meas_one_cur : meas_zero_cur;
      end
   end

   always_ff @(posedge core_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         state_r <= BLCR_IDLE;
      end
      else if (clk_en)
      begin
         case (state_r)
            BLCR_IDLE:
            begin
               if (start_r)
               begin
                  state_r <= BLCR_WAIT;
               end
            end
            BLCR_WAIT:
            begin
               // a rewrite restarts the wait; done in the same cycle as start_r is dropped
               if (!start_r && meas_done)
               begin
                  state_r <= BLCR_LOAD;
               end
            end
            BLCR_LOAD:
            begin
               // result_r latches pick on this step in its own process
               state_r <= start_r ? BLCR_WAIT : BLCR_IDLE;
            end
            default:
            begin
               state_r <= BLCR_IDLE;
            end
         endcase
      end
   end

   // ----------------------------------------
   // result register
   // ----------------------------------------
   // result only moves on the load step, so high and low bytes stay a pair
   always_ff @(posedge core_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         result_r <= BLCR_RESULT_RST;
      end
      else if (clk_en && (state_r == BLCR_LOAD))
      begin
         result_r <= pick;
      end
   end

   // ----------------------------------------
   // outputs and read mux
   // ----------------------------------------
   logic busy_nxt;
   logic [7:0] rdata_nxt;

   // busy must cover the start pulse cycle too, where the sequencer is still idle
   always_comb
   begin
      busy_nxt = 1'b0;
      if (wr_sel || start_r)
      begin
         busy_nxt = 1'b1;
      end
      else if (state_r == BLCR_WAIT)
      begin
         busy_nxt = 1'b1;
      end
      else
      begin
         // idle, or the load step with no rewrite pending
         busy_nxt = 1'b0;
      end
   end

   always_comb
   begin
      rdata_nxt = 8'h00;
      case (reg_raddr)
         BLCR_ADDR_SELECT:
         begin
            rdata_nxt = {7'h00, sel_r};
         end
         BLCR_ADDR_HIGH:
         begin
            rdata_nxt = {7'h00, result_r[BLCR_RESULT_W-1]};
         end
         BLCR_ADDR_LOW:
         begin
            rdata_nxt = result_r[7:0];
         end
         default:
         begin
            // unmapped addresses read zero rather than alias a register
            rdata_nxt = 8'h00;
         end
      endcase
   end

   // ----------------------------------------
   // output registers, one process per output
   // ----------------------------------------
   always_ff @(posedge core_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         meas_start <= 1'b0;
      end
      else if (clk_en)
      begin
         meas_start <= wr_sel;
      end
   end

   always_ff @(posedge core_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         meas_sel <= 1'b0;
      end
      else if (clk_en)
      begin
         meas_sel <= wr_sel ? reg_req.wdata[0] : sel_r;
      end
   end

   always_ff @(posedge core_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         meas_busy <= 1'b0;
      end
      else if (clk_en)
      begin
         meas_busy <= busy_nxt;
      end
   end

   // registered read data costs a cycle but keeps the output glitch free
   always_ff @(posedge core_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         reg_rdata <= 8'h00;
      end
      else if (clk_en)
      begin
         reg_rdata <= rdata_nxt;
      end
   end
endmodule

/* File: blcr_readout_assertions.sv */
// checker for the buck load-current readout
`timescale 1ns/1ps
module blcr_chk
(
   input wire logic core_clk,
   input wire logic rst_b,
   input wire logic clk_en,
   input wire blcr_pkg::blcr_reg_req_s reg_req,
   input wire logic [7:0] reg_raddr,
   input wire logic [7:0] reg_rdata,
   input wire logic meas_start,
   input wire logic meas_sel,
   input wire logic meas_done,
   input wire logic meas_busy
);
   import blcr_pkg::*;
   wire w = clk_en && reg_req.wr_en && reg_req.addr == BLCR_ADDR_SELECT;
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_b);
   start_wr_a: assert property (w |=> meas_start) else $error("start");
   start_why_a: assert property ($rose(meas_start) |-> $past(w)) else $error("stray");
   busy_set_a: assert property (w |=> meas_busy) else $error("busy");
   sel_pick_a: assert property (w |=> meas_sel == $past(reg_req.wdata[0])) else $error("sel");
   sel_read_a: assert property (clk_en && !w && reg_raddr == BLCR_ADDR_SELECT
      |=> reg_rdata == {7'h0, meas_sel}) else $error("sel read");
   high_resv_a: assert property (clk_en && reg_raddr == BLCR_ADDR_HIGH
      |=> reg_rdata[7:1] == 7'h0) else $error("resv");
   busy_hold_a: assert property (meas_busy && !meas_done && !$past(meas_done)
      |=> meas_busy) else $error("hold");
   busy_end_a: assert property (meas_busy && !meas_start && meas_done && clk_en && !w
      ##1 clk_en && !w |=> !meas_busy) else $error("end");
   cover property (w ##1 meas_start);
   cover property (meas_busy && meas_done);
   cover property ($fell(meas_busy));
endmodule
bind blcr_readout blcr_chk i_blcr_chk (.core_clk, .rst_b, .clk_en, .reg_req, .reg_raddr,
   .reg_rdata, .meas_start, .meas_sel, .meas_done, .meas_busy);

/* File: blcr_readout_tb.sv */
// testbench for the buck load-current readout
`timescale 1ns/1ps
module blcr_readout_tb;
   import blcr_pkg::*;
   logic core_clk = 1'b0, rst_b = 1'b0, clk_en = 1'b1, meas_done = 1'b0;
   logic dual_phase = 1'b0, master_is_one = 1'b0, meas_start, meas_sel, meas_busy;
   blcr_reg_req_s reg_req = '0;
   logic [7:0] reg_raddr = 8'h0, reg_rdata;
   logic [8:0] meas_zero_cur = 9'h0, meas_one_cur = 9'h0;
   int n_fail = 0, n_tests = 0, i;
   always #5 core_clk = ~core_clk;
   blcr_readout i_blcr_readout (.core_clk, .rst_b, .clk_en, .reg_req, .reg_raddr, .reg_rdata,
      .meas_start, .meas_sel, .meas_done, .meas_zero_cur, .meas_one_cur, .dual_phase,
      .master_is_one, .meas_busy);
   task give_verdict;
      $display("tests %0d fails %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   task chk(input logic [8:0] s, e);
      n_tests++;
      if (s !== e)
      begin
         n_fail++;
         $display("CHECK FAILED %0t %h %h", $time, s, e);
      end
   endtask
   task step;
      @(posedge core_clk) #1;
   endtask
   task rd(input logic [7:0] a, input logic [8:0] e);
      reg_raddr = a;
      step;
      chk(reg_rdata, e);
   endtask
   // reserved select bits left zero, as the host must
   task m(input logic s, d, k, input logic [8:0] z, o, e);
      dual_phase = d;
      master_is_one = k;
      meas_zero_cur = z;
      meas_one_cur = o;
      reg_req = '{1'b1, BLCR_ADDR_SELECT, {7'h00, s}};
      step;
      reg_req.wr_en = 1'b0;
      chk(meas_start, 1'b1);
      chk(meas_sel, s);
      chk(meas_busy, 1'b1);
      rd(BLCR_ADDR_SELECT, s);
      chk(meas_busy, 1'b1);
      chk(meas_start, 1'b0);
      meas_done = 1'b1;
      step;
      meas_done = 1'b0;
      for (i = 0; i < 20 && meas_busy !== 1'b0; i++)
         step;
      if (i == 20)
      begin
         n_fail++;
         give_verdict;
      end
      meas_zero_cur = 9'h0;
      meas_one_cur = 9'h0;
      rd(BLCR_ADDR_HIGH, e[8]);
      rd(BLCR_ADDR_LOW, e[7:0]);
   endtask
   initial
   begin
      repeat (3) @(posedge core_clk);
      #1 rst_b = 1'b1;
      rd(BLCR_ADDR_HIGH, 9'h0);
      rd(BLCR_ADDR_LOW, 9'h1);
      rd(8'h30, 9'h0);
      // a write while frozen must not be taken
      clk_en = 1'b0;
      reg_req = '{1'b1, BLCR_ADDR_SELECT, 8'h01};
      step;
      reg_req.wr_en = 1'b0;
      clk_en = 1'b1;
      chk(meas_start, 1'b0);
      chk(meas_busy, 1'b0);
      rd(BLCR_ADDR_SELECT, 9'h0);
      m(1'b0, 1'b0, 1'b0, 9'h1ff, 9'h003, 9'h1ff);
      m(1'b1, 1'b0, 1'b0, 9'h1ff, 9'h0a5, 9'h0a5);
      m(1'b0, 1'b1, 1'b0, 9'h100, 9'h023, 9'h123);
      m(1'b1, 1'b1, 1'b0, 9'h100, 9'h023, 9'h023);
      m(1'b1, 1'b1, 1'b1, 9'h0c0, 9'h055, 9'h115);
      m(1'b0, 1'b1, 1'b1, 9'h0c0, 9'h055, 9'h0c0);
      m(1'b1, 1'b1, 1'b1, 9'h1ff, 9'h1ff, 9'h1ff);
      // reset after the last measurement has finished brings back the reset values
      rst_b = 1'b0;
      step;
      rst_b = 1'b1;
      rd(BLCR_ADDR_SELECT, 9'h0);
      rd(BLCR_ADDR_HIGH, 9'h0);
      rd(BLCR_ADDR_LOW, 9'h1);
      give_verdict;
   end
endmodule
